// *** hdl/vdi_pkg.sv ***
// constants of the video decoder interrupt unit
package vdi_pkg;
  localparam logic [7:0] OFS_CONFIG     = 8'h40;
  localparam logic [7:0] OFS_LOCK_STAT  = 8'h42;
  localparam logic [7:0] OFS_LOCK_CLR   = 8'h43;
  localparam logic [7:0] OFS_LOCK_MASK  = 8'h44;
  localparam logic [7:0] OFS_FC_RAW     = 8'h45;
  localparam logic [7:0] OFS_FC_STAT    = 8'h46;
  localparam logic [7:0] OFS_FC_CLR     = 8'h47;
  localparam logic [7:0] OFS_FC_MASK    = 8'h48;
  localparam logic [7:0] OFS_SYNC_RAW   = 8'h49;
  localparam logic [7:0] OFS_SYNC_STAT  = 8'h4A;
  localparam logic [7:0] OFS_SYNC_CLR   = 8'h4B;
  localparam logic [7:0] OFS_SYNC_MASK  = 8'h4C;
  localparam logic [1:0] SUB_MAP_IRQ    = 2'h1;
  // config register fields
  localparam int CFG_DRIVE_LSB = 0;
  localparam int CFG_SWIRQ_BIT = 2;
  localparam int CFG_CP_LSB    = 4;
  localparam int CFG_LEN_LSB   = 6;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // lock event bits
  localparam int LK_GAINED = 0;
  localparam int LK_LOST   = 1;
  localparam int LK_FREE   = 5;
  localparam int LK_COPY   = 6;
  localparam logic [7:0] LK_USED = 8'h63;
  // field/caption bits
  localparam int FC_CAPTION = 0;
  localparam int FC_FIELD   = 4;
  localparam int FC_RANGE   = 5;
  localparam int FC_SWIRQ   = 7;
  localparam logic [7:0] FC_USED = 8'hB1;
  // sync change bits
  localparam int SY_OUTSTD = 0;
  localparam int SY_VLOCK  = 1;
  localparam int SY_HLOCK  = 2;
  localparam int SY_AUTO   = 3;
  localparam int SY_SECAM  = 4;
  localparam int SY_SWING  = 5;
  localparam logic [7:0] SY_USED = 8'h3F;
  // drive styles, pulse lengths and copy-protect selects
  localparam logic [1:0] DRV_OPEN_DRAIN = 2'h0;
  localparam logic [1:0] DRV_LOW        = 2'h1;
  localparam logic [1:0] DRV_HIGH       = 2'h2;
  localparam logic [1:0] LEN_UNTIL_CLR  = 2'h3;
  localparam int LEN0_PERIODS = 3;
  localparam int LEN1_PERIODS = 15;
  localparam int LEN2_PERIODS = 63;
  localparam logic [1:0] CP_PSEUDO = 2'h1;
  localparam logic [1:0] CP_STRIPE = 2'h2;
  localparam logic [1:0] CP_EITHER = 2'h3;
endpackage

// *** hdl/vdi_interrupt_unit.sv ***
// interrupt unit: latched events, clears, masks and interrupt pin
// Behaviour
// RULE1: host selects interrupt sub map first
// RULE2: pin drive style open drain/low/high
// RULE3: pin pulse 3, 15, 63 periods or held
// RULE4: manual enable raises software status bit
// RULE5: copy-protect select picks pseudo, stripe, either
// RULE6: unlocked to locked sets lock-gained bit
// RULE7: locked to unlocked sets lock-lost bit
// RULE8: free-run status change sets latched bit
// RULE9: selected copy-protect detection sets latched bit
// RULE10: clear registers write-only, one clears bit
// RULE11: mask registers read/write, one allows
// RULE12: raw status read-only live conditions
// RULE13: raw field bit one for even field
// RULE14: range violation bit with clear, mask
// RULE15: caption raw live, latched held till clear
// RULE16: field change sets field-toggle latched bit
// RULE17: raw output rate and sync lock bits
// RULE18: output standard change sets latched bit
// RULE19: vsync, hsync, secam lock changes latch
// RULE20: autodetect result change sets latched bit
// RULE21: swinging burst lock change sets bit
// RULE22: unmasked set bit asserts interrupt pin
// RULE23: latched bit held until software clears
`timescale 1ns/1ps
`default_nettype none
module vdi_interrupt_unit
  import vdi_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] sub_map_select,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  input  wire logic       decoderLocked,
  input  wire logic       freeRun,
  input  wire logic       pseudoSync,
  input  wire logic       colourStripe,
  input  wire logic       captionDetect,
  input  wire logic       evenField,
  input  wire logic       rangeViolation,
  input  wire logic       outputRate50,
  input  wire logic       vertLock,
  input  wire logic       horizLock,
  input  wire logic       secamLock,
  input  wire logic [2:0] autoStandard,
  input  wire logic       swingLock,
  output logic            irqOut,
  output logic            irqOe
);
  // two-stage synchronisers on all decoder conditions (15 bits)
  localparam int NS = 15;
  logic [NS-1:0] rawIn;
  logic [NS-1:0] sync1_q;
  logic [NS-1:0] sync2_q;
  logic [NS-1:0] prev_q;
  logic          primed_q;
  // history holds a real sample only three edges after release
  logic [1:0]    warm_q;
  assign rawIn = {swingLock, autoStandard, secamLock, horizLock, vertLock,
                  outputRate50, rangeViolation, evenField, captionDetect,
                  colourStripe, pseudoSync, freeRun, decoderLocked};
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync1_q  <= '0;
      sync2_q  <= '0;
      prev_q   <= '0;
      warm_q   <= 2'b00;
      primed_q <= 1'b0;
    end else begin
      sync1_q  <= rawIn;
      sync2_q  <= sync1_q;
      prev_q   <= sync2_q;
      warm_q   <= {warm_q[0], 1'b1};
      primed_q <= warm_q[1];
    end
  end
  logic lockS, freeS, psS, csS, capS, evenS, rangeS, rateS;
  logic vS, hS, secS, swS;
  logic [2:0] autoS;
  assign {swS, autoS, secS, hS, vS, rateS, rangeS, evenS, capS, csS, psS,
          freeS, lockS} = sync2_q;
  // no change events until the history register holds a real sample
  logic [NS-1:0] chg;
  assign chg = primed_q ? (sync2_q ^ prev_q) : '0;

  // register access only with the interrupt sub map selected
  logic selMap, wrEn;
  assign selMap = (sub_map_select == SUB_MAP_IRQ); // RULE1
  assign wrEn   = regWrite && selMap;

  logic [7:0] config_q;
  logic [7:0] lockMask_q, fcMask_q, syMask_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      config_q   <= CFG_RESET;
      lockMask_q <= 8'h00;
      fcMask_q   <= 8'h00;
      syMask_q   <= 8'h00;
    end else if (wrEn) begin
      if (regAddr == OFS_CONFIG)    config_q   <= regWdata;
      if (regAddr == OFS_LOCK_MASK) lockMask_q <= regWdata & LK_USED; // RULE11
      if (regAddr == OFS_FC_MASK)   fcMask_q   <= regWdata & FC_USED; // RULE11
      if (regAddr == OFS_SYNC_MASK) syMask_q   <= regWdata & SY_USED; // RULE11
    end
  end
  logic [1:0] driveSel, cpSel, lenSel;
  logic       swEnable;
  assign driveSel = config_q[CFG_DRIVE_LSB +: 2];
  assign cpSel    = config_q[CFG_CP_LSB +: 2];
  assign lenSel   = config_q[CFG_LEN_LSB +: 2];
  assign swEnable = config_q[CFG_SWIRQ_BIT];

  // write-one clear strobes; clear registers store nothing
  logic [7:0] lockClr, fcClr, syClr;
  assign lockClr = (wrEn && regAddr == OFS_LOCK_CLR) ? regWdata
                 : 8'h00; // RULE10
  assign fcClr   = (wrEn && regAddr == OFS_FC_CLR)   ? regWdata
                 : 8'h00; // RULE10
  assign syClr   = (wrEn && regAddr == OFS_SYNC_CLR) ? regWdata
                 : 8'h00; // RULE10

  // event sets
  logic       cpHit;
  logic [7:0] lockSet, fcSet, sySet;
  always_comb begin
    cpHit = 1'b0;
    unique case (cpSel) // RULE5
      CP_PSEUDO: cpHit = psS;
      CP_STRIPE: cpHit = csS;
      CP_EITHER: cpHit = psS || csS;
      default:   cpHit = 1'b0;
    endcase
  end
  always_comb begin
    lockSet = 8'h00;
    lockSet[LK_GAINED] = chg[0] && lockS;   // RULE6
    lockSet[LK_LOST]   = chg[0] && !lockS;  // RULE7
    lockSet[LK_FREE]   = chg[1];            // RULE8
    lockSet[LK_COPY]   = cpHit;             // RULE9
    fcSet = 8'h00;
    fcSet[FC_CAPTION] = capS;               // RULE15
    fcSet[FC_FIELD]   = chg[5];             // RULE16
    fcSet[FC_RANGE]   = rangeS;             // RULE14
    fcSet[FC_SWIRQ]   = swEnable;           // RULE4
    sySet = 8'h00;
    sySet[SY_OUTSTD] = chg[7];              // RULE18
    sySet[SY_VLOCK]  = chg[8];              // RULE19
    sySet[SY_HLOCK]  = chg[9];              // RULE19
    sySet[SY_SECAM]  = chg[10];             // RULE19
    sySet[SY_AUTO]   = |chg[13:11];         // RULE20
    sySet[SY_SWING]  = chg[NS-1];           // RULE21
  end

  // sticky flags; a set in the clearing cycle wins
  logic [7:0] lockStat_q, fcStat_q, syStat_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lockStat_q <= 8'h00;
      fcStat_q   <= 8'h00;
      syStat_q   <= 8'h00;
    end else begin
      lockStat_q <= ((lockStat_q & ~lockClr) | lockSet) & LK_USED; // RULE23
      fcStat_q   <= ((fcStat_q & ~fcClr) | fcSet) & FC_USED;       // RULE23
      syStat_q   <= ((syStat_q & ~syClr) | sySet) & SY_USED;       // RULE23
    end
  end

  // raw views
  logic [7:0] fcRaw, syRaw;
  assign fcRaw = {2'b00, rangeS, evenS, 3'b000, capS}; // RULE12 RULE13 RULE15
  assign syRaw = {3'b000, secS, 1'b0, hS, vS, rateS};  // RULE12 RULE17

  // read data, registered; unmapped or other sub map reads zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      if (!selMap) begin
        regRdata <= 8'h00;
      end else begin
        unique case (regAddr)
          OFS_CONFIG:    regRdata <= config_q;
          OFS_LOCK_STAT: regRdata <= lockStat_q;
          OFS_LOCK_MASK: regRdata <= lockMask_q;
          OFS_FC_RAW:    regRdata <= fcRaw;
          OFS_FC_STAT:   regRdata <= fcStat_q;
          OFS_FC_MASK:   regRdata <= fcMask_q;
          OFS_SYNC_RAW:  regRdata <= syRaw;
          OFS_SYNC_STAT: regRdata <= syStat_q;
          OFS_SYNC_MASK: regRdata <= syMask_q;
          default:       regRdata <= 8'h00;
        endcase
      end
    end
  end

  // pin pulse: started when pending goes from no cause to some cause
  logic pending, pendingPrev_q, rise;
  logic [5:0] pulseCnt_q;
  logic [5:0] pulseLen;
  logic       active;
  assign pending = |(lockStat_q & lockMask_q) | |(fcStat_q & fcMask_q)
                 | |(syStat_q & syMask_q); // RULE22
  assign rise = pending && !pendingPrev_q;
  always_comb begin
    unique case (lenSel) // RULE3
      2'h0:    pulseLen = 6'(LEN0_PERIODS);
      2'h1:    pulseLen = 6'(LEN1_PERIODS);
      default: pulseLen = 6'(LEN2_PERIODS);
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pendingPrev_q <= 1'b0;
      pulseCnt_q    <= 6'h00;
    end else begin
      pendingPrev_q <= pending;
      if (rise) pulseCnt_q <= pulseLen; // RULE3
      else if (pulseCnt_q != 6'h00) pulseCnt_q <= pulseCnt_q - 6'h01;
    end
  end
  // limitation: a pulse only restarts after all pending causes clear
  assign active = (lenSel == LEN_UNTIL_CLR) ? pending
                : (rise || pulseCnt_q > 6'h01);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irqOut <= 1'b0;
      irqOe  <= 1'b0;
    end else begin
      unique case (driveSel) // RULE2
        DRV_OPEN_DRAIN: begin
          irqOut <= 1'b0;
          irqOe  <= active;
        end
        DRV_LOW: begin
          irqOut <= !active;
          irqOe  <= 1'b1;
        end
        DRV_HIGH: begin
          irqOut <= active;
          irqOe  <= 1'b1;
        end
        default: begin
          irqOut <= 1'b0;
          irqOe  <= 1'b0;
        end
      endcase
    end
  end

  // checks
  property p_lock_gain;
    @(posedge clk) disable iff (!rst_b)
      (primed_q && lockS && !prev_q[0]) |=> lockStat_q[LK_GAINED];
  endproperty
  a_lock_gain: assert property (p_lock_gain) // RULE6
    else $error("lock gain lost");
  property p_lock_lost;
    @(posedge clk) disable iff (!rst_b)
      (primed_q && !lockS && prev_q[0]) |=> lockStat_q[LK_LOST];
  endproperty
  a_lock_lost: assert property (p_lock_lost) // RULE7
    else $error("lock lost missed");
  property p_hold;
    @(posedge clk) disable iff (!rst_b)
      (syStat_q[SY_VLOCK] && !syClr[SY_VLOCK]) |=> syStat_q[SY_VLOCK];
  endproperty
  a_hold: assert property (p_hold) // RULE23
    else $error("flag dropped");
  property p_clear;
    @(posedge clk) disable iff (!rst_b)
      (fcClr[FC_FIELD] && !chg[5]) |=> !fcStat_q[FC_FIELD];
  endproperty
  a_clear: assert property (p_clear) // RULE10
    else $error("clear ignored");
  property p_sw;
    @(posedge clk) disable iff (!rst_b)
      swEnable |=> fcStat_q[FC_SWIRQ];
  endproperty
  a_sw: assert property (p_sw) // RULE4
    else $error("soft irq missing");
  property p_mask;
    @(posedge clk) disable iff (!rst_b)
      (!pending && lenSel == LEN_UNTIL_CLR && driveSel == DRV_HIGH)
      |=> !irqOut;
  endproperty
  a_mask: assert property (p_mask) // RULE22
    else $error("irq without cause");
  property p_pulse3;
    @(posedge clk) disable iff (!rst_b)
      (rise && lenSel == 2'h0 && driveSel == DRV_HIGH &&
       $stable(config_q)) |=> irqOut [*3] ##1 !irqOut;
  endproperty
  a_pulse3: assert property (p_pulse3) // RULE3
    else $error("pulse length wrong");
  property p_od;
    @(posedge clk) disable iff (!rst_b)
      (driveSel == DRV_OPEN_DRAIN && $stable(driveSel)) |=> !irqOut;
  endproperty
  a_od: assert property (p_od) // RULE2
    else $error("open drain drove high");
  property p_drv_low;
    @(posedge clk) disable iff (!rst_b)
      (driveSel == DRV_LOW) |=> irqOe;
  endproperty
  a_drv_low: assert property (p_drv_low) // RULE2
    else $error("drive low style let go of pin");
  property p_free;
    @(posedge clk) disable iff (!rst_b)
      chg[1] |=> lockStat_q[LK_FREE];
  endproperty
  a_free: assert property (p_free) // RULE8
    else $error("free-run change missed");
  property p_copy;
    @(posedge clk) disable iff (!rst_b)
      (cpSel == CP_EITHER && (psS || csS)) |=> lockStat_q[LK_COPY];
  endproperty
  a_copy: assert property (p_copy) // RULE9
    else $error("copy-protect event missed");
  property p_copy_sel;
    @(posedge clk) disable iff (!rst_b)
      (cpSel == CP_STRIPE && !csS && !lockStat_q[LK_COPY])
      |=> !lockStat_q[LK_COPY];
  endproperty
  a_copy_sel: assert property (p_copy_sel) // RULE5
    else $error("copy-protect set by unselected event");
  property p_field;
    @(posedge clk) disable iff (!rst_b)
      chg[5] |=> fcStat_q[FC_FIELD];
  endproperty
  a_field: assert property (p_field) // RULE16
    else $error("field change missed");
  property p_auto;
    @(posedge clk) disable iff (!rst_b)
      (|chg[13:11]) |=> syStat_q[SY_AUTO];
  endproperty
  a_auto: assert property (p_auto) // RULE20
    else $error("autodetect change missed");
  property p_swing;
    @(posedge clk) disable iff (!rst_b)
      chg[NS-1] |=> syStat_q[SY_SWING];
  endproperty
  a_swing: assert property (p_swing) // RULE21
    else $error("swinging burst change missed");
  c_pin: cover property (@(posedge clk) disable iff (!rst_b) irqOe && irqOut);
  c_held: cover property (@(posedge clk) disable iff (!rst_b)
    lenSel == LEN_UNTIL_CLR && irqOut);
  c_gain: cover property (@(posedge clk) disable iff (!rst_b)
    lockSet[LK_GAINED]);
  c_auto: cover property (@(posedge clk) disable iff (!rst_b) sySet[SY_AUTO]);
endmodule
`default_nettype wire

// *** bench/vdi_host.sv ***
// host model: register access tasks and the pulled-up irq line
`timescale 1ns/1ps
`default_nettype none
module vdi_host
  import vdi_pkg::*;
(
  input  wire logic       clk,
  output logic      [1:0] sub_map_select,
  output logic            regWrite,
  output logic            regRead,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWdata,
  input  wire logic [7:0] regRdata,
  input  wire logic       irqOut,
  input  wire logic       irqOe,
  output logic            pin
);
  initial begin
    sub_map_select = SUB_MAP_IRQ;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
  end
  // pull-up holds the line high whenever the unit lets go of it
  assign pin = irqOe ? irqOut : 1'b1;
  // released address and data show the inverse, never the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge clk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~v;
  endtask
  task automatic sel(input logic [1:0] m);
    @(posedge clk);
    sub_map_select <= m;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    @(posedge clk);
    v = regRdata;
  endtask
endmodule
`default_nettype wire

// *** bench/vdi_interrupt_unit_tb.sv ***
// self-checking bench of the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module vdi_interrupt_unit_tb;
  import vdi_pkg::*;
  logic        clk;
  logic        rst_b;
  logic        pin;
  logic        irqOut;
  logic        irqOe;
  logic [1:0]  subMap;
  logic        regWrite;
  logic        regRead;
  logic [7:0]  regAddr;
  logic [7:0]  regWdata;
  logic [7:0]  regRdata;
  logic [7:0]  d;
  logic [7:0]  r;
  logic [1:0]  s;
  logic [14:0] ev;
  logic [14:0] o;
  logic [14:0] x;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          seed = 32'h3B7DCDD3;
  int          cnt;
  int          l;
  vdi_host vdi_host_i (
    .clk(clk), .sub_map_select(subMap), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .irqOut(irqOut), .irqOe(irqOe), .pin(pin)
  );
  vdi_interrupt_unit vdi_interrupt_unit_i (
    .clk(clk), .rst_b(rst_b), .sub_map_select(subMap),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata),
    .decoderLocked(ev[0]), .freeRun(ev[1]), .pseudoSync(ev[2]),
    .colourStripe(ev[3]), .captionDetect(ev[4]), .evenField(ev[5]),
    .rangeViolation(ev[6]), .outputRate50(ev[7]), .vertLock(ev[8]),
    .horizLock(ev[9]), .secamLock(ev[10]), .autoStandard(ev[13:11]),
    .swingLock(ev[14]), .irqOut(irqOut), .irqOe(irqOe)
  );
  task automatic chk(string w, logic [7:0] seen, logic [7:0] e);
    num_checks++;
    if (seen !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h seen %h", w, e, seen);
    end
  endtask
  task automatic rc(logic [7:0] a, logic [7:0] e);
    vdi_host_i.rd(a, d);
    chk($sformatf("reg %h", a), d, e);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    vdi_host_i.wr(a, v);
  endtask
  function automatic int plen(int k);
    return k == 0 ? LEN0_PERIODS : k == 1 ? LEN1_PERIODS : LEN2_PERIODS;
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #(50 * 100000);
    n_mismatch++;
    final_report();
  end
  initial begin
    rst_b = 1'b0;
    ev = 15'($random(seed));
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rc(OFS_CONFIG, CFG_RESET);
    rc(8'h41, 8'h00);
    rc(OFS_LOCK_STAT, 8'h00);
    r = {2'b00, ev[6], 4'h0, ev[4]};
    rc(OFS_FC_STAT, r);
    rc(OFS_SYNC_STAT, 8'h00);
    for (int k = 0; k < 3; k++) begin
      r = 8'($random(seed));
      rc(OFS_LOCK_MASK + 8'(4 * k), 8'h00);
      wr(OFS_LOCK_MASK + 8'(4 * k), r);
      s = 2'(k);
      r = r & (s == 0 ? LK_USED : s == 1 ? FC_USED : SY_USED);
      rc(OFS_LOCK_MASK + 8'(4 * k), r);
      rc(OFS_LOCK_CLR + 8'(4 * k), 8'h00);
      wr(OFS_LOCK_MASK + 8'(4 * k), 8'h00);
    end
    // a foreign sub map must neither write nor read this map
    vdi_host_i.sel(2'h2);
    wr(OFS_LOCK_MASK, 8'hFF);
    rc(OFS_LOCK_MASK, 8'h00);
    vdi_host_i.sel(SUB_MAP_IRQ);
    rc(OFS_LOCK_MASK, 8'h00);
    for (int i = 0; i < 24; i++) begin
      s = 2'($random(seed));
      o = ev;
      wr(OFS_CONFIG, {2'b00, s, 4'h0});
      wr(OFS_LOCK_CLR, 8'hFF);
      wr(OFS_FC_CLR, 8'hFF);
      wr(OFS_SYNC_CLR, 8'hFF);
      ev <= 15'($random(seed));
      repeat (6) @(posedge clk);
      x = o ^ ev;
      wr(OFS_FC_RAW, 8'hFF);
      r = {2'b00, ev[6:5], 3'b000, ev[4]};
      rc(OFS_FC_RAW, r);
      rc(OFS_SYNC_RAW, {3'b000, ev[10], 1'b0, ev[9:7]});
      r = {2'b00, o[6] | ev[6], x[5], 3'b000, o[4] | ev[4]};
      rc(OFS_FC_STAT, r);
      r = {2'b00, x[14], x[10], |x[13:11], x[9:7]};
      rc(OFS_SYNC_STAT, r);
      r = {1'b0, s[0] & (o[2] | ev[2]) | s[1] & (o[3] | ev[3]), x[1],
           3'b000, o[0] & ~ev[0], ~o[0] & ev[0]};
      rc(OFS_LOCK_STAT, r);
      wr(OFS_LOCK_CLR, 8'h01);
      rc(OFS_LOCK_STAT, r & 8'hFE);
    end
    wr(OFS_FC_MASK, 8'h80);
    for (int i = 0; i < 10; i++) begin
      l = (i == 9) ? 0 : i / 3;
      if (i == 9)
        wr(OFS_FC_MASK, 8'h00);
      wr(OFS_CONFIG, {l[1:0], 3'b000, 1'b1, 2'(i % 3)});
      cnt = 0;
      // the old drive style still shows for one cycle after the write
      @(posedge clk);
      repeat (80) begin
        @(negedge clk);
        cnt += (i % 3 == 2) ? pin : !pin;
      end
      d = (i == 9) ? 8'h00 : 8'(plen(l));
      chk("pin", 8'(cnt), d);
      vdi_host_i.rd(OFS_FC_STAT, d);
      chk("swirq", d & 8'h80, 8'h80);
      wr(OFS_CONFIG, {6'h00, 2'(i % 3)});
      wr(OFS_FC_CLR, 8'h80);
    end
    // held style stays asserted until software clears the cause
    wr(OFS_FC_MASK, 8'h80);
    wr(OFS_CONFIG, 8'hC6);
    repeat (80) @(negedge clk);
    chk("held", {7'h00, pin}, 8'h01);
    wr(OFS_CONFIG, 8'hC2);
    wr(OFS_FC_CLR, 8'h80);
    repeat (3) @(negedge clk);
    chk("held", {7'h00, pin}, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
